// >>> core/iad_pkg.sv
// package for the integer execution datapath: opcodes, request/result carriers,
// register numbers, flag layout and fixed ranges. assumes a 32-bit core.
package iad_pkg;

   // ********************************
   // fixed values
   // ********************************
   localparam logic [3:0] IAD_REG_SP = 4'hd;
   localparam logic [3:0] IAD_REG_PC = 4'hf;
   localparam logic [11:0] IAD_IMM_TWELVE_MAX = 12'hfff;
   localparam logic [7:0] IAD_SP_LSL_MAX = 8'h03;
   localparam logic [5:0] IAD_SHR_IMM_MIN = 6'h01;
   localparam logic [5:0] IAD_SHR_IMM_MAX = 6'h20;
   localparam logic [5:0] IAD_LSL_IMM_MAX = 6'h1f;
   localparam logic [5:0] IAD_ROR_IMM_MAX = 6'h1f;
   localparam logic [7:0] IAD_SHIFT_SAT = 8'h20;
   localparam logic [5:0] IAD_SHIFT_CLAMP = 6'h21;
   localparam logic [31:0] IAD_PC_WORD_MASK = 32'hffff_fffc;
   localparam logic [31:0] IAD_PC_HALF_MASK = 32'hffff_fffe;
   localparam logic [3:0] IAD_FLAGS_RESET = 4'h0;

   // shift applied to a register flexible operand
   localparam logic [1:0] IAD_FSH_NONE = 2'h0;
   localparam logic [1:0] IAD_FSH_LSL = 2'h1;
   localparam logic [1:0] IAD_FSH_OTHER = 2'h2;

   // condition codes
   localparam logic [3:0] IAD_CC_EQ = 4'h0;
   localparam logic [3:0] IAD_CC_NE = 4'h1;
   localparam logic [3:0] IAD_CC_CS = 4'h2;
   localparam logic [3:0] IAD_CC_CC = 4'h3;
   localparam logic [3:0] IAD_CC_MI = 4'h4;
   localparam logic [3:0] IAD_CC_PL = 4'h5;
   localparam logic [3:0] IAD_CC_VS = 4'h6;
   localparam logic [3:0] IAD_CC_VC = 4'h7;
   localparam logic [3:0] IAD_CC_HI = 4'h8;
   localparam logic [3:0] IAD_CC_LS = 4'h9;
   localparam logic [3:0] IAD_CC_GE = 4'ha;
   localparam logic [3:0] IAD_CC_LT = 4'hb;
   localparam logic [3:0] IAD_CC_GT = 4'hc;
   localparam logic [3:0] IAD_CC_LE = 4'hd;

   // ********************************
   // types
   // ********************************
   typedef enum logic [4:0] {
      IAD_ADD = 5'h00,
      IAD_ADD_CARRY = 5'h01,
      IAD_SUB = 5'h02,
      IAD_SUB_CARRY = 5'h03,
      IAD_REVERSE_SUB = 5'h04,
      IAD_AND = 5'h05,
      IAD_OR = 5'h06,
      IAD_XOR = 5'h07,
      IAD_AND_NOT = 5'h08,
      IAD_OR_NOT = 5'h09,
      IAD_ARITH_SHIFT_RIGHT = 5'h0a,
      IAD_LOGICAL_SHIFT_LEFT = 5'h0b,
      IAD_LOGICAL_SHIFT_RIGHT = 5'h0c,
      IAD_ROTATE_RIGHT = 5'h0d,
      IAD_ROTATE_EXTEND = 5'h0e,
      IAD_COUNT_LEADING_ZEROS = 5'h0f
   } iad_op_t;

   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } iad_flags_t;

   typedef struct packed {
      logic valid;
      iad_op_t op;
      logic set_flags;
      logic [3:0] cond;
      logic use_imm_twelve;
      logic [11:0] imm_twelve;
      logic dest_given;
      logic [3:0] dest_idx;
      logic [3:0] first_idx;
      logic [31:0] first_val;
      logic [31:0] flex_val;
      logic flex_is_reg;
      logic [3:0] flex_reg_idx;
      logic [1:0] flex_shift_kind;
      logic [7:0] flex_shift_amt;
      logic flex_carry;
      logic flex_carry_valid;
      logic [3:0] src_idx;
      logic [31:0] src_val;
      logic shift_by_reg;
      logic [5:0] shift_imm;
      logic [31:0] shift_amount_val;
   } iad_req_t;

   typedef struct packed {
      logic done;
      logic wb_en;
      logic [3:0] wb_idx;
      logic [31:0] wb_data;
      logic branch;
      logic [31:0] branch_target;
      logic illegal;
      logic skipped;
   } iad_res_t;

endpackage

// >>> core/iad_datapath.sv
// integer add/subtract, logic, shift/rotate and leading-zero datapath.
// assumes decode hands over one request per cycle with register values already
// read, and that the register file takes the write-back one cycle later.
`timescale 1ns/1ns
`default_nettype none

module iad_datapath
   import iad_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // request from decode
   input wire iad_req_t req,
   // result to register file and fetch
   output iad_res_t res_r,
   output iad_flags_t flags_r
);

   // ********************************
   // functions
   // ********************************
   function automatic logic cond_ok(input logic [3:0] cc, input iad_flags_t f);
      logic ok;
      ok = 1'b1;
      case (cc)
         IAD_CC_EQ: ok = f.z;
         IAD_CC_NE: ok = !f.z;
         IAD_CC_CS: ok = f.c;
         IAD_CC_CC: ok = !f.c;
         IAD_CC_MI: ok = f.n;
         IAD_CC_PL: ok = !f.n;
         IAD_CC_VS: ok = f.v;
         IAD_CC_VC: ok = !f.v;
         IAD_CC_HI: ok = f.c && !f.z;
         IAD_CC_LS: ok = !f.c || f.z;
         IAD_CC_GE: ok = f.n == f.v;
         IAD_CC_LT: ok = f.n != f.v;
         IAD_CC_GT: ok = !f.z && (f.n == f.v);
         IAD_CC_LE: ok = f.z || (f.n != f.v);
         default: ok = 1'b1;
      endcase
      return ok;
   endfunction

   function automatic logic [5:0] lead_zeros(input logic [31:0] x);
      logic [5:0] cnt;
      logic seen;
      cnt = 6'h00;
      seen = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         if (x[i]) begin
            seen = 1'b1;
         end
         if (!seen) begin
            cnt = cnt + 6'h01;
         end
      end
      return cnt;
   endfunction

   function automatic logic is_pc_or_sp(input logic [3:0] idx);
      return (idx == IAD_REG_PC) || (idx == IAD_REG_SP);
   endfunction

   // ********************************
   // reset release
   // ********************************
   logic rst_meta_n_r;
   logic rst_n_r;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_n_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_n_r <= 1'b1;
         rst_n_r <= rst_meta_n_r;
      end
   end

   // ********************************
   // operation classes
   // ********************************
   wire is_add = req.op == IAD_ADD;
   wire is_sub = req.op == IAD_SUB;
   wire is_addsub = is_add || is_sub;
   wire is_arith = req.op inside {IAD_ADD, IAD_ADD_CARRY, IAD_SUB, IAD_SUB_CARRY,
                                  IAD_REVERSE_SUB};
   wire is_logic = req.op inside {IAD_AND, IAD_OR, IAD_XOR, IAD_AND_NOT, IAD_OR_NOT};
   wire is_shift = req.op inside {IAD_ARITH_SHIFT_RIGHT, IAD_LOGICAL_SHIFT_LEFT,
                                  IAD_LOGICAL_SHIFT_RIGHT, IAD_ROTATE_RIGHT,
                                  IAD_ROTATE_EXTEND};
   wire is_clz = req.op == IAD_COUNT_LEADING_ZEROS;

   // imm_twelve form only exists for plain add/sub; wide forms arrive the same way
   wire imm_form = req.use_imm_twelve && is_addsub;

   // shifts and leading zeros name their destination explicitly
   wire [3:0] dest = (req.dest_given || is_shift || is_clz) ? req.dest_idx
                                                            : req.first_idx;

   // ********************************
   // operand form checks
   // ********************************
   wire flex_unshifted = req.flex_shift_kind == IAD_FSH_NONE;
   wire flex_small_lsl = flex_unshifted ||
      ((req.flex_shift_kind == IAD_FSH_LSL) && (req.flex_shift_amt <= IAD_SP_LSL_MAX));
   wire flex_const_ok = imm_form ||
      (!req.flex_is_reg && (req.flex_val <= {20'h00000, IAD_IMM_TWELVE_MAX}));

   wire pc_branch = is_add && (dest == IAD_REG_PC) && (req.first_idx == IAD_REG_PC) &&
      !req.use_imm_twelve && req.flex_is_reg && flex_unshifted && !req.set_flags &&
      !is_pc_or_sp(req.flex_reg_idx);

   // shifts and leading zeros never read the first operand; its index is don't-care there
   wire uses_first = is_arith || is_logic;

   wire bad_first_pc = uses_first && (req.first_idx == IAD_REG_PC) && !pc_branch &&
      !(is_addsub && !req.set_flags && flex_const_ok);
   wire bad_dest_pc = (dest == IAD_REG_PC) && !pc_branch;
   wire bad_sp = ((dest == IAD_REG_SP) &&
                  !(is_addsub && (req.first_idx == IAD_REG_SP) &&
                    (imm_form || !req.flex_is_reg || flex_small_lsl))) ||
                 (uses_first && (req.first_idx == IAD_REG_SP) && !is_addsub);
   wire bad_flex = (is_arith || is_logic) && !imm_form && req.flex_is_reg &&
                   is_pc_or_sp(req.flex_reg_idx) && !pc_branch;
   wire bad_other = (is_logic && is_pc_or_sp(dest)) ||
                    ((is_shift || is_clz) &&
                     (is_pc_or_sp(dest) || is_pc_or_sp(req.src_idx)));

   // immediate shift counts
   wire bad_imm_cnt = is_shift && !req.shift_by_reg && (
      ((req.op == IAD_ARITH_SHIFT_RIGHT || req.op == IAD_LOGICAL_SHIFT_RIGHT) &&
       (req.shift_imm < IAD_SHR_IMM_MIN || req.shift_imm > IAD_SHR_IMM_MAX)) ||
      ((req.op == IAD_LOGICAL_SHIFT_LEFT) && (req.shift_imm > IAD_LSL_IMM_MAX)) ||
      ((req.op == IAD_ROTATE_RIGHT) &&
       (req.shift_imm < IAD_SHR_IMM_MIN || req.shift_imm > IAD_ROR_IMM_MAX)));

   wire illegal = bad_first_pc || bad_dest_pc || bad_sp || bad_flex || bad_other ||
                  bad_imm_cnt;
   wire pass = cond_ok(req.cond, flags_r);

   // ********************************
   // adder
   // ********************************
   wire [31:0] base = (req.first_idx == IAD_REG_PC) ? (req.first_val & IAD_PC_WORD_MASK)
                                                    : req.first_val;
   wire [31:0] opnd2 = imm_form ? {20'h00000, req.imm_twelve} : req.flex_val;

   // every arithmetic form is x + y + cin on a 33-bit adder
   logic [31:0] add_x;
   logic [31:0] add_y;
   logic add_cin;

   always_comb begin
      add_x = base;
      add_y = opnd2;
      add_cin = 1'b0;
      case (req.op)
         IAD_ADD_CARRY: add_cin = flags_r.c;
         IAD_SUB: begin
            add_y = ~opnd2;
            add_cin = 1'b1;
         end
         IAD_SUB_CARRY: begin
            add_y = ~opnd2;
            add_cin = flags_r.c;
         end
         IAD_REVERSE_SUB: begin
            add_x = opnd2;
            add_y = ~base;
            add_cin = 1'b1;
         end
         default: add_cin = 1'b0;
      endcase
   end

   wire [32:0] sum33 = {1'b0, add_x} + {1'b0, add_y} + {32'h0, add_cin};
   wire [31:0] sum = sum33[31:0];
   // carry out is also "no borrow" for the inverted-operand forms
   wire add_c = sum33[32];
   wire add_v = (add_x[31] == add_y[31]) && (sum[31] != add_x[31]);

   // ********************************
   // logic unit
   // ********************************
   logic [31:0] logic_res;

   always_comb begin
      case (req.op)
         IAD_AND: logic_res = req.first_val & req.flex_val;
         IAD_OR: logic_res = req.first_val | req.flex_val;
         IAD_XOR: logic_res = req.first_val ^ req.flex_val;
         IAD_AND_NOT: logic_res = req.first_val & ~req.flex_val;
         IAD_OR_NOT: logic_res = req.first_val | ~req.flex_val;
         default: logic_res = 32'h0000_0000;
      endcase
   end

   // ********************************
   // shifter
   // ********************************
   wire [7:0] shift_cnt = req.shift_by_reg ? req.shift_amount_val[7:0]
                                           : {2'h0, req.shift_imm};
   // counts beyond 32 behave like 33: logical shifts clear value and carry, arithmetic right fills both with the sign bit
   wire [5:0] cnt_c = (shift_cnt > IAD_SHIFT_SAT) ? IAD_SHIFT_CLAMP : shift_cnt[5:0];
   wire [63:0] lsl64 = {32'h0000_0000, req.src_val} << cnt_c;
   wire [63:0] lsr64 = {req.src_val, 32'h0000_0000} >> cnt_c;
   wire [63:0] asr64 = $signed({req.src_val, 32'h0000_0000}) >>> cnt_c;
   wire [63:0] ror64 = {req.src_val, req.src_val} >> shift_cnt[4:0];
   wire [31:0] ror_res = ror64[31:0];

   logic [31:0] shift_res;
   logic shift_c;

   always_comb begin
      shift_res = req.src_val;
      shift_c = flags_r.c;
      case (req.op)
         IAD_LOGICAL_SHIFT_LEFT: begin
            shift_res = lsl64[31:0];
            shift_c = lsl64[32];
         end
         IAD_LOGICAL_SHIFT_RIGHT: begin
            shift_res = lsr64[63:32];
            shift_c = lsr64[31];
         end
         IAD_ARITH_SHIFT_RIGHT: begin
            shift_res = asr64[63:32];
            shift_c = asr64[31];
         end
         IAD_ROTATE_RIGHT: begin
            shift_res = ror_res;
            shift_c = ror_res[31];
         end
         IAD_ROTATE_EXTEND: begin
            shift_res = {flags_r.c, req.src_val[31:1]};
            shift_c = req.src_val[0];
         end
         default: shift_c = flags_r.c;
      endcase
      // a zero count leaves value and carry as they were, except for rotate extend
      if (shift_cnt == 8'h00 && req.op != IAD_ROTATE_EXTEND) begin
         shift_res = req.src_val;
         shift_c = flags_r.c;
      end
   end

   // ********************************
   // result and flag selection
   // ********************************
   wire [31:0] clz_res = {26'h0000000, lead_zeros(req.src_val)};
   wire [31:0] result = is_arith ? sum :
                        is_logic ? logic_res :
                        is_shift ? shift_res : clz_res;

   iad_flags_t flags_nxt;

   always_comb begin
      flags_nxt = flags_r;
      if (is_arith) begin
         flags_nxt.n = sum[31];
         flags_nxt.z = sum == 32'h0000_0000;
         flags_nxt.c = add_c;
         flags_nxt.v = add_v;
      end else if (is_logic) begin
         flags_nxt.n = logic_res[31];
         flags_nxt.z = logic_res == 32'h0000_0000;
         if (req.flex_carry_valid) begin
            flags_nxt.c = req.flex_carry;
         end
      end else if (is_shift) begin
         flags_nxt.n = shift_res[31];
         flags_nxt.z = shift_res == 32'h0000_0000;
         flags_nxt.c = shift_c;
      end
   end

   // leading zeros never touches the flags
   wire take = req.valid && !illegal && pass;
   wire flag_we = take && req.set_flags && !is_clz && !pc_branch;

   iad_res_t res_nxt;

   always_comb begin
      res_nxt = '0;
      res_nxt.done = req.valid;
      res_nxt.illegal = req.valid && illegal;
      res_nxt.skipped = req.valid && !illegal && !pass;
      // shift results land in dest only; source register is never written
      res_nxt.wb_en = take && !pc_branch;
      res_nxt.wb_idx = dest;
      res_nxt.wb_data = result;
      res_nxt.branch = take && pc_branch;
      res_nxt.branch_target = sum & IAD_PC_HALF_MASK;
   end

   // ********************************
   // registers
   // ********************************
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         res_r <= '0;
         flags_r <= IAD_FLAGS_RESET;
      end else begin
         res_r <= res_nxt;
         if (flag_we) begin
            flags_r <= flags_nxt;
         end
      end
   end

endmodule

`default_nettype wire

// >>> tb/iad_datapath_asserts.sv
// checker for the integer datapath: timing and outcome relations at the ports.
// assumes one clock domain and the single datapath instance it is bound to.
`timescale 1ns/1ns
`default_nettype none
module iad_datapath_asserts
   import iad_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // watched ports
   input wire iad_req_t req,
   input wire iad_res_t res_r,
   input wire iad_flags_t flags_r
);
   // ****************
   // properties
   // ****************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // internal reset lets go two edges after the pin, so done is only owed after that
   a_done_follows_req: assert property (
      $past(nrst) && $past(nrst, 2) && $past(nrst, 3) |-> res_r.done == $past(req.valid))
      else $error("done does not follow request by one cycle");
   a_single_outcome: assert property (
      res_r.done |-> $onehot({res_r.wb_en, res_r.branch, res_r.illegal, res_r.skipped}))
      else $error("result carries zero or several outcomes");
   a_refused_keeps_flags: assert property (
      (res_r.skipped || res_r.illegal) |-> $stable(flags_r))
      else $error("flags moved on a refused or skipped request");
   a_no_suffix_flags: assert property (
      req.valid && !req.set_flags |=> $stable(flags_r))
      else $error("flags moved without the flag suffix");
   a_add_imm_sum: assert property (
      req.valid && req.op == IAD_ADD && req.use_imm_twelve &&
      req.cond >= 4'he && req.first_idx < IAD_REG_SP && req.dest_given &&
      req.dest_idx < IAD_REG_SP |=> res_r.wb_en &&
      res_r.wb_data == $past(req.first_val) + {20'h0, $past(req.imm_twelve)})
      else $error("immediate add result wrong");
   a_pc_base_word: assert property (
      req.valid && req.op == IAD_ADD && req.use_imm_twelve &&
      req.first_idx == IAD_REG_PC && !req.set_flags && req.cond >= 4'he &&
      req.dest_given && req.dest_idx < IAD_REG_SP |=> res_r.wb_data ==
      ($past(req.first_val) & IAD_PC_WORD_MASK) + {20'h0, $past(req.imm_twelve)})
      else $error("pc base not word aligned");
   a_shift_dest_only: assert property (
      req.valid && req.op >= IAD_ARITH_SHIFT_RIGHT &&
      req.cond >= 4'he |=> res_r.illegal || res_r.wb_idx == $past(req.dest_idx))
      else $error("shift wrote other than its destination");
   a_logic_keeps_v: assert property (
      req.valid && req.op >= IAD_AND &&
      req.op <= IAD_OR_NOT |=> flags_r.v == $past(flags_r.v))
      else $error("logic op changed overflow");
   a_clz_keeps_flags: assert property (
      req.valid && req.op == IAD_COUNT_LEADING_ZEROS |=> $stable(flags_r))
      else $error("leading zero count changed flags");
   a_branch_even: assert property (
      res_r.branch |-> !res_r.branch_target[0] && !res_r.wb_en)
      else $error("branch target odd or written back");
   a_sp_dest_refused: assert property (
      req.valid && req.dest_given &&
      req.dest_idx == IAD_REG_SP && req.first_idx < IAD_REG_SP && req.cond >= 4'he
      |=> res_r.illegal)
      else $error("stack pointer destination accepted");
endmodule
bind iad_datapath iad_datapath_asserts i_chk (.clk(clk), .nrst(nrst), .req(req),
   .res_r(res_r), .flags_r(flags_r));
`default_nettype wire

// >>> tb/iad_regfile_model.sv
// register file model standing behind the datapath: applies write-backs.
// assumes write-back is taken on the edge after the result appears.
`timescale 1ns/1ns
`default_nettype none
module iad_regfile_model
   import iad_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // write-back in
   input wire iad_res_t res,
   // register values out
   output logic [31:0] rf [16]
);
   // distinct reset pattern so a wrong index shows up as a wrong value
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 16; i++) rf[i] <= {8{4'(i)}};
      end else if (res.wb_en) begin
         rf[res.wb_idx] <= res.wb_data;
      end
   end
endmodule
`default_nettype wire

// >>> tb/iad_datapath_test.sv
// self-checking bench for the integer datapath with a register file model.
// assumes the result and flags appear one cycle after each request.
`timescale 1ns/1ns
`default_nettype none
module iad_datapath_test;
   import iad_pkg::*;
   typedef struct packed {iad_res_t res; iad_flags_t fl;} iad_exp_t;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   iad_req_t req = '0;
   iad_res_t res_r;
   iad_flags_t flags_r, mfl;
   logic [31:0] rf [16];
   iad_exp_t exp_q[$];
   iad_exp_t e_w, g_w;
   iad_req_t q;
   int err_total = 0;
   int num_checks = 0;
   int cyc = 0;

   iad_datapath i_dut (.clk(clk), .nrst(nrst), .req(req), .res_r(res_r), .flags_r(flags_r));
   iad_regfile_model i_rf (.clk(clk), .nrst(nrst), .res(res_r), .rf(rf));

   always #20 clk = ~clk;

   // ****************
   // reference
   // ****************
   function automatic logic cond_ok(logic [3:0] cc, iad_flags_t f);
      case (cc)
         IAD_CC_EQ: return f.z;
         IAD_CC_NE: return !f.z;
         IAD_CC_CS: return f.c;
         IAD_CC_CC: return !f.c;
         IAD_CC_MI: return f.n;
         IAD_CC_PL: return !f.n;
         IAD_CC_VS: return f.v;
         IAD_CC_VC: return !f.v;
         IAD_CC_HI: return f.c && !f.z;
         IAD_CC_LS: return !f.c || f.z;
         IAD_CC_GE: return f.n == f.v;
         IAD_CC_LT: return f.n != f.v;
         IAD_CC_GT: return !f.z && f.n == f.v;
         IAD_CC_LE: return f.z || f.n != f.v;
         default: return 1'b1;
      endcase
   endfunction

   function automatic iad_exp_t ref_op(iad_req_t q, iad_flags_t f);
      iad_exp_t e;
      logic [31:0] x, m, y, v;
      logic [32:0] s;
      logic [63:0] w;
      logic signed [63:0] ws;
      logic ci, c, ar, sh;
      logic [7:0] n;
      e = '0;
      e.fl = f;
      e.res.done = 1'b1;
      if (!cond_ok(q.cond, f)) begin
         e.res.skipped = 1'b1;
         return e;
      end
      x = (q.first_idx == IAD_REG_PC) ? q.first_val & IAD_PC_WORD_MASK : q.first_val;
      m = q.use_imm_twelve ? {20'h0, q.imm_twelve} : q.flex_val;
      v = q.src_val;
      n = q.shift_by_reg ? q.shift_amount_val[7:0] : {2'h0, q.shift_imm};
      c = f.c;
      ci = 1'b0;
      y = '0;
      ar = q.op <= IAD_REVERSE_SUB;
      sh = q.op >= IAD_ARITH_SHIFT_RIGHT && q.op <= IAD_ROTATE_RIGHT;
      case (q.op)
         IAD_ADD_CARRY: ci = f.c;
         IAD_SUB: {m, ci} = {~m, 1'b1};
         IAD_SUB_CARRY: {m, ci} = {~m, f.c};
         IAD_REVERSE_SUB: {x, m, ci} = {m, ~x, 1'b1};
         default: ;
      endcase
      s = {1'b0, x} + {1'b0, m} + 33'(ci);
      case (q.op)
         IAD_AND: y = x & m;
         IAD_OR: y = x | m;
         IAD_XOR: y = x ^ m;
         IAD_AND_NOT: y = x & ~m;
         IAD_OR_NOT: y = x | ~m;
         IAD_LOGICAL_SHIFT_LEFT: begin
            w = {32'h0, v} << n;
            {c, y} = w[32:0];
         end
         IAD_LOGICAL_SHIFT_RIGHT: begin
            w = {v, 32'h0} >> n;
            {y, c} = w[63:31];
         end
         IAD_ARITH_SHIFT_RIGHT: begin
            ws = {v, 32'h0};
            ws = ws >>> n;
            {y, c} = ws[63:31];
         end
         IAD_ROTATE_RIGHT: begin
            y = (v >> n[4:0]) | (v << (6'd32 - 6'(n[4:0])));
            c = y[31];
         end
         IAD_ROTATE_EXTEND: {y, c} = {f.c, v};
         IAD_COUNT_LEADING_ZEROS: begin
            y = 32'h20;
            for (int i = 0; i < 32; i++) if (v[i]) y = 32'(31 - i);
         end
         default: {c, y} = s;
      endcase
      if (sh && n == 8'h0) c = f.c;
      if (q.set_flags && q.op != IAD_COUNT_LEADING_ZEROS) begin
         e.fl.n = y[31];
         e.fl.z = y == 32'h0;
         if (ar || q.op >= IAD_ARITH_SHIFT_RIGHT) e.fl.c = c;
         else if (q.flex_carry_valid) e.fl.c = q.flex_carry;
         if (ar) e.fl.v = x[31] == m[31] && y[31] != x[31];
      end
      e.res.wb_en = 1'b1;
      e.res.wb_data = y;
      e.res.wb_idx = (q.op >= IAD_ARITH_SHIFT_RIGHT || q.dest_given) ? q.dest_idx : q.first_idx;
      return e;
   endfunction

   // ****************
   // driving and checking
   // ****************
   function automatic iad_req_t mk(iad_op_t op, logic [31:0] a, logic [31:0] b);
      iad_req_t r;
      r = '0;
      r.valid = 1'b1;
      r.op = op;
      r.cond = 4'he;
      r.set_flags = 1'b1;
      r.dest_given = 1'b1;
      r.dest_idx = 4'h2;
      r.first_idx = 4'h1;
      r.first_val = a;
      r.flex_val = b;
      r.src_idx = 4'h1;
      r.src_val = a;
      r.shift_imm = 6'h01;
      return r;
   endfunction

   // md: 0 computed, 1 refused form, 2 pc branch
   task automatic send(input iad_req_t r, input int md);
      iad_exp_t e;
      e = '0;
      e.fl = mfl;
      e.res.done = 1'b1;
      if (md == 0) e = ref_op(r, mfl);
      e.res.illegal = md == 1;
      e.res.branch = md == 2;
      if (md == 2) e.res.branch_target = (r.first_val + r.flex_val) & IAD_PC_HALF_MASK;
      mfl = e.fl;
      exp_q.push_back(e);
      req <= r;
      @(posedge clk);
   endtask

   always @(negedge clk) begin
      if (res_r.done === 1'b1) begin
         g_w.res = res_r;
         g_w.fl = flags_r;
         if (res_r.wb_en !== 1'b1) {g_w.res.wb_idx, g_w.res.wb_data} = '0;
         if (res_r.branch !== 1'b1) g_w.res.branch_target = '0;
         e_w = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
         num_checks++;
         if (g_w !== e_w) begin
            err_total++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e_w, g_w);
         end
      end
   end

   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // 2000 cycles is several times the planned traffic
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         complete_run();
      end
   end

   initial begin
      mfl = IAD_FLAGS_RESET;
      void'($urandom(35051));
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      num_checks++;
      if ({res_r, flags_r} !== {73'h0, IAD_FLAGS_RESET}) begin
         err_total++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, {73'h0, IAD_FLAGS_RESET},
                  {res_r, flags_r});
      end
      q = mk(IAD_ADD, 32'h5, 32'h0);
      q.use_imm_twelve = 1'b1;
      q.imm_twelve = 12'h3;
      send(q, 0);
      send(mk(IAD_ADD, 32'h7fff_ffff, 32'h1), 0);
      send(mk(IAD_SUB, 32'h9, 32'h9), 0);
      send(mk(IAD_SUB_CARRY, 32'h9, 32'h9), 0);
      send(mk(IAD_SUB, 32'h0, 32'h1), 0);
      send(mk(IAD_SUB_CARRY, 32'h9, 32'h2), 0);
      send(mk(IAD_ADD_CARRY, 32'hffff_ffff, 32'h1), 0);
      q = mk(IAD_SUB, 32'h1000, 32'h0);
      q.use_imm_twelve = 1'b1;
      q.imm_twelve = IAD_IMM_TWELVE_MAX;
      q.dest_given = 1'b0;
      q.first_idx = 4'h4;
      send(q, 0);
      q.op = IAD_ADD;
      q.first_idx = IAD_REG_PC;
      q.first_val = 32'h1003;
      q.set_flags = 1'b0;
      q.dest_given = 1'b1;
      send(q, 0);
      q.first_idx = IAD_REG_SP;
      q.dest_idx = IAD_REG_SP;
      send(q, 0);
      q = mk(IAD_ADD, 32'h2000, 32'h7);
      q.first_idx = IAD_REG_PC;
      q.dest_idx = IAD_REG_PC;
      q.set_flags = 1'b0;
      q.flex_is_reg = 1'b1;
      q.flex_reg_idx = 4'h2;
      send(q, 2);
      q = mk(IAD_ADD, 32'h1, 32'h1);
      q.dest_idx = IAD_REG_SP;
      send(q, 1);
      q = mk(IAD_ADD, 32'h1, 32'h1);
      q.first_idx = IAD_REG_PC;
      send(q, 1);
      q = mk(IAD_ADD, 32'h10, 32'h40);
      q.first_idx = IAD_REG_SP;
      q.dest_idx = IAD_REG_SP;
      q.flex_is_reg = 1'b1;
      q.flex_reg_idx = 4'h2;
      q.flex_shift_kind = IAD_FSH_LSL;
      q.flex_shift_amt = 8'h04;
      send(q, 1);
      q.flex_shift_amt = IAD_SP_LSL_MAX;
      send(q, 0);
      q = mk(IAD_AND_NOT, 32'hff, 32'hf);
      q.flex_carry_valid = 1'b1;
      q.flex_carry = 1'b1;
      send(q, 0);
      for (int i = 0; i < 4; i++) begin
         q = mk(iad_op_t'(5'h0a + 5'(i)), 32'h1, 32'h0);
         q.shift_imm = (i == 1) ? 6'h20 : 6'h00;
         send(q, 1);
      end
      q.shift_imm = 6'h20;
      send(q, 1);
      send(mk(IAD_COUNT_LEADING_ZEROS, 32'h0, 32'h0), 0);
      send(mk(IAD_COUNT_LEADING_ZEROS, 32'h8000_0000, 32'h0), 0);
      send(mk(IAD_ROTATE_EXTEND, 32'h3, 32'h0), 0);
      for (int i = 0; i < 300; i++) begin
         q = '0;
         q.valid = 1'b1;
         q.op = iad_op_t'($urandom % 16);
         q.set_flags = 1'($urandom);
         q.cond = ($urandom % 4 == 0) ? 4'($urandom) : 4'he;
         q.first_idx = 4'($urandom % 13);
         q.first_val = rf[q.first_idx];
         q.dest_given = 1'($urandom);
         q.dest_idx = 4'($urandom % 13);
         q.flex_val = $urandom;
         q.flex_carry_valid = 1'($urandom);
         q.flex_carry = 1'($urandom);
         q.use_imm_twelve = (q.op == IAD_ADD || q.op == IAD_SUB) && ($urandom % 2 == 0);
         q.imm_twelve = 12'($urandom);
         q.src_idx = 4'($urandom % 13);
         q.src_val = rf[q.src_idx];
         q.shift_by_reg = 1'($urandom);
         q.shift_amount_val = {24'($urandom), 8'($urandom % 40)};
         q.shift_imm = 6'($urandom % 32) + 6'(q.op != IAD_LOGICAL_SHIFT_LEFT);
         if (q.op == IAD_ROTATE_RIGHT && q.shift_imm == 6'h20) q.shift_imm = 6'h1f;
         send(q, 0);
      end
      req <= '0;
      repeat (3) @(posedge clk);
      num_checks++;
      if (exp_q.size() != 0) begin
         err_total++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, 0, exp_q.size());
      end
      complete_run();
   end
endmodule
`default_nettype wire
